//--- nibble_port_pkg.sv
// Constants shared by the nibble port block and its pulse-width bank.
// Assumes a 250 MHz mclk that stands in for the 2 MHz system clock.
package nibble_port_pkg;

	// ==========================================================
	// Timing.
	localparam int MCLK_HZ = 250_000_000;
	localparam int MCLK_PERIOD_NS = 4;
	localparam int SYS_CLK_HZ = 2_000_000;
	localparam int INSTR_TIME_NS = 4000;
	localparam int IR_CARRIER_HZ = 38500;
	localparam int SYS_DIV = MCLK_HZ / SYS_CLK_HZ;
	localparam int INSTR_CYCLES = INSTR_TIME_NS / MCLK_PERIOD_NS;
	localparam int IR_HALF_CYCLES = MCLK_HZ / (2 * IR_CARRIER_HZ);
	localparam int SYS_DIV_W = 7;
	localparam int INSTR_W = 10;
	localparam int IR_W = 12;

	// ==========================================================
	// Pin map: port_a 3:0, port_b 7:4, port_c 11:8, port_d 15:12.
	localparam int PIN_COUNT = 16;
	localparam int PORT_WIDTH = 4;
	localparam int PORT_B_BIT3 = 7;
	localparam int PORT_C_BIT3 = 11;
	localparam int PWM_BASE = 8;
	localparam int PWM_COUNT = 4;
	localparam int DUTY_W = 8;
	localparam int IR_MODE_BIT = 3;

	// ==========================================================
	// Reset values.
	localparam logic [15:0] PIN_RESET = 16'h0000;
	localparam logic [7:0] PWM_CNT_RESET = 8'h00;

	typedef enum logic {
		RUN = 1'b0,
		STOP = 1'b1
	} power_state_t;

endpackage : nibble_port_pkg

//--- pwm_if.sv
// Carrier between the port block and its pulse-width bank.
// Assumes both ends run on the same mclk.
`timescale 1ns/1ps
interface pwm_if;
	logic [31:0] duty;
	logic tick;
	logic [3:0] wave;

	modport bank (
		input duty,
		input tick,
		output wave
	);

	modport ctrl (
		output duty,
		output tick,
		input wave
	);
endinterface : pwm_if

//--- pwm_bank.sv
// Four pulse-width channels sharing one 256-count period.
// Assumes tick is a one-cycle pulse at the system clock rate.
`timescale 1ns/1ps
module pwm_bank (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	pwm_if.bank pwm
);

	// ==========================================================
	// Period counter.
	logic [7:0] count;

	always_ff @(posedge mclk) begin
		if (rst) begin
			count <= nibble_port_pkg::PWM_CNT_RESET;
		end else if (ce && pwm.tick) begin
			count <= count + 8'h01;
		end
	end

	// ==========================================================
	// Compare per channel; a zero duty never wins the compare.
	genvar ch;
	generate
		for (ch = 0; ch < nibble_port_pkg::PWM_COUNT; ch++) begin : g_ch
			always_ff @(posedge mclk) begin
				if (rst) begin
					pwm.wave[ch] <= 1'b0;
				end else if (ce) begin
					pwm.wave[ch] <= count < pwm.duty[ch*8 +: 8];
				end
			end
		end
	endgenerate

endmodule : pwm_bank

//--- nibble_port_ir_pwm_wake.sv
// General-purpose pin block: four nibble ports, infrared carrier, four
// pulse-width pins and pin-change wake from stop mode.
// Assumes pin inputs are asynchronous and control ports come from mclk logic.
//
// Contract
// - Logic paced by 2 MHz clock, 4 us instructions.
// - Four 4-bit ports, sixteen pins total.
// - Each bit independently pulled-down input or output.
// - End instruction enters stop, halting system clock.
// - Any pin transition wakes from stop.
// - Mode control bit 3 enables infrared.
// - Infrared modulates port_c bit3 with 38.5 kHz.
// - Select bit routes infrared to port_b or port_c.
// - Pulse-width outputs on port_c bits 0-3.
// - Each pulse-width pin has 8-bit duty.
`timescale 1ns/1ps
module nibble_port_ir_pwm_wake (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [15:0] pinIn,
	input wire logic [15:0] dirOut,
	input wire logic [15:0] outVal,
	input wire logic [3:0] modeCtrl,
	input wire logic irPinSelectBit,
	input wire logic [3:0] pwmEnable,
	input wire logic [31:0] pwmDuty,
	input wire logic endInstr,
	output logic [15:0] pinOut,
	output logic [15:0] pinOe,
	output logic [15:0] pullDownEn,
	output logic [15:0] portRead,
	output logic instrTick,
	output logic sysClkRun
);

	// ==========================================================
	// Pin synchronisers.
	logic [15:0] pinMeta;
	logic [15:0] pinSync;
	logic [15:0] pinPrev;

	always_ff @(posedge mclk) begin
		if (rst) begin
			pinMeta <= nibble_port_pkg::PIN_RESET;
			pinSync <= nibble_port_pkg::PIN_RESET;
			pinPrev <= nibble_port_pkg::PIN_RESET;
		end else if (ce) begin
			pinMeta <= pinIn;
			pinSync <= pinMeta;
			pinPrev <= pinSync;
		end
	end

	// ==========================================================
	// Stop mode and wake.
	// Wake reads the synchronised pins, so a pulse shorter than one mclk
	// period may be missed; keys are far slower than that.
	nibble_port_pkg::power_state_t state;
	logic wake;

	assign wake = (pinSync != pinPrev);

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= nibble_port_pkg::RUN;
		end else if (ce) begin
			unique case (state)
				nibble_port_pkg::RUN: begin
					if (endInstr) begin
						state <= nibble_port_pkg::STOP;
					end
				end
				nibble_port_pkg::STOP: begin
					if (wake) begin
						state <= nibble_port_pkg::RUN;
					end
				end
			endcase
		end
	end

	assign sysClkRun = (state == nibble_port_pkg::RUN);

	// ==========================================================
	// System clock and instruction pacing; both freeze in stop.
	logic [6:0] sysDiv;
	logic [9:0] instrDiv;
	logic sysTick;

	assign sysTick = sysClkRun && (sysDiv == 7'(nibble_port_pkg::SYS_DIV - 1));

	always_ff @(posedge mclk) begin
		if (rst) begin
			sysDiv <= 7'h00;
		end else if (ce && sysClkRun) begin
			sysDiv <= sysTick ? 7'h00 : sysDiv + 7'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			instrDiv <= 10'h000;
			instrTick <= 1'b0;
		end else if (ce) begin
			instrTick <= 1'b0;
			if (sysClkRun) begin
				if (instrDiv == 10'(nibble_port_pkg::INSTR_CYCLES - 1)) begin
					instrDiv <= 10'h000;
					instrTick <= 1'b1;
				end else begin
					instrDiv <= instrDiv + 10'h001;
				end
			end
		end
	end

	// ==========================================================
	// Port settings take effect once per instruction.
	logic [15:0] dirLatch;
	logic [15:0] valLatch;
	logic [3:0] pwmEnLatch;

	always_ff @(posedge mclk) begin
		if (rst) begin
			dirLatch <= nibble_port_pkg::PIN_RESET;
			valLatch <= nibble_port_pkg::PIN_RESET;
			pwmEnLatch <= 4'h0;
		end else if (ce && instrTick) begin
			dirLatch <= dirOut;
			valLatch <= outVal;
			pwmEnLatch <= pwmEnable;
		end
	end

	// ==========================================================
	// Infrared carrier, running only while enabled and awake.
	logic [11:0] irDiv;
	logic carrier;
	logic irOn;

	assign irOn = modeCtrl[nibble_port_pkg::IR_MODE_BIT];

	always_ff @(posedge mclk) begin
		if (rst) begin
			irDiv <= 12'h000;
			carrier <= 1'b0;
		end else if (ce) begin
			if (!irOn) begin
				irDiv <= 12'h000;
				carrier <= 1'b0;
			end else if (sysClkRun) begin
				if (irDiv == 12'(nibble_port_pkg::IR_HALF_CYCLES - 1)) begin
					irDiv <= 12'h000;
					carrier <= ~carrier;
				end else begin
					irDiv <= irDiv + 12'h001;
				end
			end
		end
	end

	// ==========================================================
	// Pulse-width bank.
	pwm_if pwm ();

	assign pwm.duty = pwmDuty;
	assign pwm.tick = sysTick;

	pwm_bank u_pwm (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.pwm(pwm)
	);

	// ==========================================================
	// Pin drive. Infrared outranks pulse-width on port_c bit3 because
	// the carrier would otherwise be chopped by the duty wave.
	logic [15:0] next_pinOut;
	logic [15:0] next_pinOe;
	logic irPin;

	always_comb begin
		next_pinOut = valLatch;
		next_pinOe = dirLatch;
		for (int i = 0; i < nibble_port_pkg::PWM_COUNT; i++) begin
			if (pwmEnLatch[i]) begin
				next_pinOut[nibble_port_pkg::PWM_BASE + i] = pwm.wave[i];
				next_pinOe[nibble_port_pkg::PWM_BASE + i] = 1'b1;
			end
		end
		irPin = valLatch[nibble_port_pkg::PORT_C_BIT3] & carrier;
		if (irOn) begin
			if (irPinSelectBit) begin
				next_pinOut[nibble_port_pkg::PORT_B_BIT3] = irPin;
				next_pinOe[nibble_port_pkg::PORT_B_BIT3] = 1'b1;
			end else begin
				next_pinOut[nibble_port_pkg::PORT_C_BIT3] = irPin;
				next_pinOe[nibble_port_pkg::PORT_C_BIT3] = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pinOut <= nibble_port_pkg::PIN_RESET;
			pinOe <= nibble_port_pkg::PIN_RESET;
			pullDownEn <= ~nibble_port_pkg::PIN_RESET;
			portRead <= nibble_port_pkg::PIN_RESET;
		end else if (ce) begin
			pinOut <= next_pinOut;
			pinOe <= next_pinOe;
			pullDownEn <= ~next_pinOe;
			portRead <= pinSync;
		end
	end

endmodule : nibble_port_ir_pwm_wake

//--- nibble_port_properties.sv
// Checker on the top ports of the nibble port block.
// Assumes ce is held high.
`timescale 1ns/1ps
module nibble_port_properties (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [15:0] pinIn,
	input wire logic [3:0] modeCtrl,
	input wire logic irPinSelectBit,
	input wire logic endInstr,
	input wire logic [15:0] pinOe,
	input wire logic [15:0] pullDownEn,
	input wire logic [15:0] portRead,
	input wire logic instrTick,
	input wire logic sysClkRun
);
	// ==========
	// Properties.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_wake_cause;
		!sysClkRun && $changed(pinIn);
	endsequence
	a_pull_down_mirror: assert property (pullDownEn == ~pinOe)
		else $error("pull-down wrong");
	a_stop_entry: assert property (endInstr && sysClkRun |=> !sysClkRun)
		else $error("no stop");
	a_tick_single: assert property (instrTick |=> !instrTick [*8])
		else $error("tick too long");
	a_stop_no_tick: assert property (!sysClkRun && !$past(sysClkRun) |-> !instrTick)
		else $error("tick in stop");
	a_pin_wake: assert property (s_wake_cause |-> ##[1:4] sysClkRun)
		else $error("no wake");
	a_oe_paced: assert property ($changed(pinOe[6:0]) |-> $past(instrTick, 2))
		else $error("drive off tick");
	a_ir_on_b: assert property ((modeCtrl[3] && irPinSelectBit) [*3] |-> pinOe[7])
		else $error("ir b pin");
	a_ir_on_c: assert property ((modeCtrl[3] && !irPinSelectBit) [*3] |-> pinOe[11])
		else $error("ir c pin");
	a_read_sync: assert property (sysClkRun && $past(sysClkRun, 4) |-> portRead == $past(pinIn, 3))
		else $error("read lag");
endmodule : nibble_port_properties

bind nibble_port_ir_pwm_wake nibble_port_properties u_props (.mclk(mclk), .rst(rst),
	.pinIn(pinIn), .modeCtrl(modeCtrl), .irPinSelectBit(irPinSelectBit), .endInstr(endInstr),
	.pinOe(pinOe), .pullDownEn(pullDownEn), .portRead(portRead), .instrTick(instrTick),
	.sysClkRun(sysClkRun));

//--- pin_loads.sv
// Keys and loads on the sixteen pins.
// Assumes an undriven pin rests at its pull-down unless a key holds it high.
`timescale 1ns/1ps
module pin_loads (
	input wire logic [15:0] pinOut,
	input wire logic [15:0] pinOe,
	input wire logic [15:0] keys,
	output logic [15:0] pinLevel
);
	// ==========
	// Pin level.
	assign pinLevel = (pinOe & pinOut) | (~pinOe & keys);
endmodule : pin_loads

//--- nibble_port_ir_pwm_wake_tb.sv
// Self-checking bench for the nibble port block.
// Assumes the checker and pin model are compiled first.
`timescale 1ns/1ps
module nibble_port_ir_pwm_wake_tb;
	logic mclk = 1'b0, rst = 1'b1, irPinSelectBit = 1'b0, endInstr = 1'b0;
	logic [15:0] dirOut = 16'h0, outVal = 16'h0, keys = 16'h0, pinIn, pinOut, pinOe;
	logic [15:0] pullDownEn, portRead;
	logic [3:0] modeCtrl = 4'h0, pwmEnable = 4'h0;
	logic [31:0] pwmDuty = 32'h0;
	logic instrTick, sysClkRun;
	int numErrors = 0, nChecks = 0, cycles = 0, k;
	// ==========
	// Structure.
	always #2 mclk = ~mclk;
	nibble_port_ir_pwm_wake u_dut (.mclk(mclk), .rst(rst), .ce(1'b1), .pinIn(pinIn),
		.dirOut(dirOut), .outVal(outVal), .modeCtrl(modeCtrl), .irPinSelectBit(irPinSelectBit),
		.pwmEnable(pwmEnable), .pwmDuty(pwmDuty), .endInstr(endInstr), .pinOut(pinOut),
		.pinOe(pinOe), .pullDownEn(pullDownEn), .portRead(portRead), .instrTick(instrTick),
		.sysClkRun(sysClkRun));
	pin_loads u_loads (.pinOut(pinOut), .pinOe(pinOe), .keys(keys), .pinLevel(pinIn));
	// ==========
	// Tasks.
	task check(input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("ERROR %0t got %h want %h", $time, seen, exp);
		end
	endtask : check
	task finish_test;
		if (numErrors == 0 && nChecks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test
	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	// Settings land only on a tick, so wait for one before looking.
	task latch(input logic [15:0] d, input logic [15:0] v);
		@(posedge mclk);
		dirOut <= d;
		outVal <= v;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (instrTick !== 1'b1 && k < 1100);
		cyc(4);
		check(pinOe, d);
		check(pinOut & d & 16'hf0ff, v & d & 16'hf0ff);
	endtask : latch
	task automatic measure(input int b, input int n, output int h, output int f);
		logic p;
		p = pinOut[b];
		h = 0;
		f = 0;
		repeat (n) begin
			@(posedge mclk);
			h += pinOut[b];
			f += (pinOut[b] != p);
			p = pinOut[b];
		end
	endtask : measure
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 70000) begin
			numErrors++;
			finish_test();
		end
	end
	// ==========
	// Sequence.
	initial begin
		int h[4], f;
		cyc(6);
		rst <= 1'b0;
		cyc(1);
		check(pullDownEn, 16'hffff);
		check(pinOe, 16'h0000);
		check(sysClkRun, 1'b1);
		latch(16'h0f5a, 16'h0c3c);
		keys <= 16'h50a0;
		cyc(5);
		check(portRead & 16'hf0a5, 16'h50a0);
		latch(16'h0000, 16'h0800);
		for (int s = 0; s < 2; s++) begin
			irPinSelectBit <= s[0];
			modeCtrl <= 4'h8;
			cyc(4);
			measure(11 - 4 * s, 7000, h[0], f);
			check(pinOe[11 - 4 * s], 1'b1);
			check(f, 2);
			check(h[0], nibble_port_pkg::IR_HALF_CYCLES);
		end
		modeCtrl <= 4'h0;
		cyc(4);
		check(pinOe, 16'h0000);
		check(pinOut[11], 1'b1);
		pwmDuty <= 32'h80ff0040;
		pwmEnable <= 4'hf;
		latch(16'h0f00, 16'h0000);
		fork
			measure(8, 32000, h[0], f);
			measure(9, 32000, h[1], f);
			measure(10, 32000, h[2], f);
			measure(11, 32000, h[3], f);
		join
		for (int i = 0; i < 4; i++) check(h[i], pwmDuty[8 * i +: 8] * nibble_port_pkg::SYS_DIV);
		pwmEnable <= 4'h0;
		latch(16'h0000, 16'h0000);
		for (int w = 0; w < 2; w++) begin
			endInstr <= 1'b1;
			cyc(1);
			endInstr <= 1'b0;
			cyc(20);
			check(sysClkRun, 1'b0);
			keys <= keys ^ 16'h0001;
			cyc(5);
			check(sysClkRun, 1'b1);
		end
		finish_test();
	end
endmodule : nibble_port_ir_pwm_wake_tb
